// ---- common/snd_defs.svh ----
// constants of the switch node command decoder
`ifndef SND_DEFS_SVH
`define SND_DEFS_SVH

// header byte layout
`define SND_CMD_MSB       7
`define SND_CMD_LSB       5
`define SND_ADDR_MSB      4
`define SND_ADDR_LSB      0

// command codes that act on the load
`define SND_CMD_LOAD_ON   3'h1
`define SND_CMD_LOAD_OFF  3'h2

// field layout: header, data, checksum
`define SND_FIELD_BYTES   3
`define SND_PULL_DATA     8'h00
`define SND_NODE_ADDR     6

// timing
`define SND_CLK_MHZ       10
`define SND_GAP_US        2000
`define SND_GAP_CYC       (`SND_GAP_US * `SND_CLK_MHZ)
`define SND_FAST_MS       100
`define SND_FAST_CYC      (`SND_FAST_MS * 1000 * `SND_CLK_MHZ)
`define SND_HOLD_MS       3000
`define SND_HOLD_CYC      (`SND_HOLD_MS * 1000 * `SND_CLK_MHZ)

`endif

// ---- common/snd_pkg.sv ----
// types of the switch node command decoder
package snd_pkg;

  // message phase of the decoder
  typedef enum logic [2:0] {
    PH_HDR,
    PH_DATA,
    PH_CSUM,
    PH_SKIP,
    PH_TXHDR,
    PH_TXDAT,
    PH_TXSUM
  } snd_phase_t;

  // header byte split into command and destination
  typedef struct packed {
    logic [2:0] cmd;
    logic [4:0] addr;
  } snd_hdr_t;

  // byte delivered by the data link
  typedef struct packed {
    logic       valid;   // one-cycle strobe
    logic [7:0] data;
    logic       csumOk;  // checksum verdict, meaningful on third byte
  } snd_rx_t;

  // byte handed to the data link
  typedef struct packed {
    logic       valid;     // held until ready
    logic [7:0] data;
    logic       appendSum; // link puts its checksum in place of data
  } snd_tx_t;

endpackage : snd_pkg

// ---- hw/snd_blinker.sv ----
// status indicator: sync toggles it, a link fault makes it flash fast
`include "snd_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module snd_blinker #(
  parameter int FAST_CYC = `SND_FAST_CYC,
  parameter int HOLD_CYC = `SND_HOLD_CYC
) (
  input  wire logic clk_sys,    // system clock
  input  wire logic rst,        // async reset, high
  input  wire logic syncPulse,  // sync message seen
  input  wire logic faultPulse, // link fault seen
  output var  logic ledOut      // indicator drive
);

  localparam int FW = $clog2(FAST_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);

  generate
    if (FAST_CYC < 1 || HOLD_CYC < FAST_CYC)
    begin : gChk
      $error("snd_blinker: bad blink timing");
    end
  endgenerate

  typedef struct packed {
    logic          led;
    logic [FW-1:0] fast;
    logic [HW-1:0] hold;
  } snd_blk_t;

  snd_blk_t q;
  snd_blk_t d;

  // fault mode wins over sync so trouble stays visible while syncs still arrive
  always_comb
  begin
    d = q;
    if (faultPulse)
    begin
      d.hold = HW'(HOLD_CYC);
    end
    else if (q.hold != '0)
    begin
      d.hold = q.hold - 1'b1;
    end
    if (q.hold != '0)
    begin
      if (q.fast == FW'(FAST_CYC - 1))
      begin
        d.fast = '0;
        d.led  = ~q.led;
      end
      else
      begin
        d.fast = q.fast + 1'b1;
      end
    end
    else
    begin
      d.fast = '0;
      if (syncPulse)
      begin
        d.led = ~q.led;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign ledOut = q.led;

  syncToggle_a : assert property (@(posedge clk_sys) disable iff (rst)
    (syncPulse && !faultPulse && q.hold == '0) |=> (ledOut != $past(ledOut)))
    else $error("sync did not toggle indicator");

  fastFlash_a : assert property (@(posedge clk_sys) disable iff (rst)
    (q.hold > HW'(1) && q.fast == FW'(FAST_CYC - 1)) |=> (ledOut != $past(ledOut)))
    else $error("fault flash missed its toggle");

  faultCov_c : cover property (@(posedge clk_sys) disable iff (rst)
    faultPulse ##1 (q.hold != '0));

endmodule : snd_blinker

`default_nettype wire

// ---- hw/snd_node.sv ----
// switch node command decoder: push field in, load control, pull field out
`include "snd_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// Function
// - A header byte holds the command in bits 7..5 and the node address in bits 4..0.
// - The master sends its push field first and only the addressed slave replies.
// - A message is six bytes: push header, data, checksum, then pull header, data, checksum.
// - Command 001 for this node switches the load on and command 010 switches it off.
// - All other command codes leave the load as it is but still get the pull reply.
// - The pull reply echoes the push header, then sends 00h, then the link checksum.
// - Each slave has its own address and acts only on commands sent to it.
// - The status indicator toggles on every sync message received while no fault flash is running.
// - A link fault makes the status indicator flash clearly faster than sync toggling.
// - A falling edge on the receive line raises a receive interrupt for each start bit.
// - The transceiver automatic standby stays disabled at all times.
module snd_node #(
  parameter int NODE_ADDR = `SND_NODE_ADDR,
  parameter int GAP_CYC   = `SND_GAP_CYC,
  parameter int FAST_CYC  = `SND_FAST_CYC,
  parameter int HOLD_CYC  = `SND_HOLD_CYC
) (
  input  wire logic            clk_sys,     // system clock
  input  wire logic            rst,         // async reset, high
  input  wire snd_pkg::snd_rx_t rxIn,       // received byte from the data link
  input  wire logic            txReady,     // data link took the offered byte
  input  wire logic            rxLine,      // serial receive line level, idle high
  input  wire logic            syncPulse,   // data link saw a sync message
  input  wire logic            linkFault,   // data link framing or timing fault
  output snd_pkg::snd_tx_t     txOut,       // byte offered to the data link
  output logic                 loadDrive,   // switched load, high is on
  output logic                 statusLed,   // status indicator
  output logic                 rxIrq,       // receive interrupt pulse
  output logic                 standbyOff   // keeps transceiver standby disabled
);

  localparam int GW = $clog2(GAP_CYC + 1);

  generate
    if (NODE_ADDR < 0 || NODE_ADDR > 31 || GAP_CYC < 2)
    begin : gChk
      $error("snd_node: unsupported parameter");
    end
  endgenerate

  localparam logic [4:0] OWN_ADDR = 5'(NODE_ADDR);

  typedef struct packed {
    snd_pkg::snd_phase_t phase;
    logic [7:0]          hdr;
    logic [1:0]          skipCnt;
    logic [GW-1:0]       gap;
    logic                load;
    snd_pkg::snd_tx_t    tx;
    logic                irq;
    logic                rxLast;
    logic                csumFail;
    logic                standbyOff;
  } snd_state_t;

  snd_state_t       q;
  snd_state_t       d;
  snd_pkg::snd_hdr_t hdrQ;
  logic             ownAddr;
  logic             csumByte;
  logic             gapOut;

  // split the stored header into command and destination
  assign hdrQ     = snd_pkg::snd_hdr_t'(q.hdr);
  // match against our own address only
  assign ownAddr  = (hdrQ.addr == OWN_ADDR);
  assign csumByte = (q.phase == snd_pkg::PH_CSUM) && rxIn.valid;
  // a lost byte must not leave the decoder stuck mid field
  assign gapOut   = (q.gap == GW'(GAP_CYC - 1));

  // next state; bytes heard during our own reply are our echo and are ignored
  always_comb
  begin
    d            = q;
    d.csumFail   = 1'b0;
    d.standbyOff = 1'b1;
    d.irq        = q.rxLast & ~rxLine;
    d.rxLast     = rxLine;
    if (rxIn.valid)
    begin
      d.gap = '0;
    end
    else if (!gapOut)
    begin
      d.gap = q.gap + 1'b1;
    end
    unique case (q.phase)
      snd_pkg::PH_HDR:
      begin
        // first byte of the push field
        if (rxIn.valid)
        begin
          d.hdr   = rxIn.data;
          d.phase = snd_pkg::PH_DATA;
        end
      end
      snd_pkg::PH_DATA:
      begin
        // data byte carries nothing for this node
        if (rxIn.valid)
        begin
          d.phase = snd_pkg::PH_CSUM;
        end
        else if (gapOut)
        begin
          d.phase = snd_pkg::PH_HDR;
        end
      end
      snd_pkg::PH_CSUM:
      begin
        if (rxIn.valid)
        begin
          d.csumFail = ~rxIn.csumOk;
          if (!ownAddr)
          begin
            // foreign field: wait out the other reply
            d.phase   = snd_pkg::PH_SKIP;
            d.skipCnt = '0;
          end
          else if (!rxIn.csumOk)
          begin
            d.phase = snd_pkg::PH_HDR;
          end
          else
          begin
            if (hdrQ.cmd == `SND_CMD_LOAD_ON)
            begin
              d.load = 1'b1;
            end
            else if (hdrQ.cmd == `SND_CMD_LOAD_OFF)
            begin
              d.load = 1'b0;
            end
            d.tx.valid     = 1'b1;
            d.tx.data      = q.hdr;
            d.tx.appendSum = 1'b0;
            d.phase        = snd_pkg::PH_TXHDR;
          end
        end
        else if (gapOut)
        begin
          d.phase = snd_pkg::PH_HDR;
        end
      end
      snd_pkg::PH_SKIP:
      begin
        // count the other slave's three pull bytes
        if (rxIn.valid)
        begin
          d.skipCnt = q.skipCnt + 1'b1;
          if (q.skipCnt == 2'(`SND_FIELD_BYTES - 1))
          begin
            d.phase = snd_pkg::PH_HDR;
          end
        end
        else if (gapOut)
        begin
          d.phase = snd_pkg::PH_HDR;
        end
      end
      snd_pkg::PH_TXHDR:
      begin
        if (txReady)
        begin
          d.tx.data = `SND_PULL_DATA;
          d.phase   = snd_pkg::PH_TXDAT;
        end
      end
      snd_pkg::PH_TXDAT:
      begin
        if (txReady)
        begin
          d.tx.data      = 8'h00;
          d.tx.appendSum = 1'b1;
          d.phase        = snd_pkg::PH_TXSUM;
        end
      end
      snd_pkg::PH_TXSUM:
      begin
        if (txReady)
        begin
          d.tx    = '0;
          d.gap   = '0;
          d.phase = snd_pkg::PH_HDR;
        end
      end
      default:
      begin
        d.phase = snd_pkg::PH_HDR;
        d.tx    = '0;
      end
    endcase
  end

  // state register; line sampled high at reset so release gives no false edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q            <= '0;
      q.phase      <= snd_pkg::PH_HDR;
      q.rxLast     <= 1'b1;
      q.standbyOff <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs come straight from the state register
  assign txOut      = q.tx;
  assign loadDrive  = q.load;
  assign rxIrq      = q.irq;
  assign standbyOff = q.standbyOff;

  // indicator timing lives in its own small module
  snd_blinker #(
    .FAST_CYC (FAST_CYC),
    .HOLD_CYC (HOLD_CYC)
  ) uBlink (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .syncPulse  (syncPulse),
    .faultPulse (q.csumFail | linkFault),
    .ledOut     (statusLed)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  loadOn_a : assert property (
    (csumByte && ownAddr && rxIn.csumOk && hdrQ.cmd == `SND_CMD_LOAD_ON) |=> loadDrive)
    else $error("load on command not applied");

  loadOff_a : assert property (
    (csumByte && ownAddr && rxIn.csumOk && hdrQ.cmd == `SND_CMD_LOAD_OFF) |=> !loadDrive)
    else $error("load off command not applied");

  otherCmds_a : assert property (
    (csumByte && ownAddr && rxIn.csumOk && hdrQ.cmd != `SND_CMD_LOAD_ON
      && hdrQ.cmd != `SND_CMD_LOAD_OFF) |=> ($stable(loadDrive) && txOut.valid))
    else $error("idle command changed load or missed reply");

  pullEcho_a : assert property (
    (csumByte && ownAddr && rxIn.csumOk) |=> (txOut.valid && txOut.data == $past(q.hdr)
      && !txOut.appendSum))
    else $error("pull header does not echo push header");

  pullData_a : assert property (
    (q.phase == snd_pkg::PH_TXHDR && txReady) |=> (txOut.valid
      && txOut.data == `SND_PULL_DATA && !txOut.appendSum))
    else $error("pull data byte not zero");

  foreignQuiet_a : assert property (
    (csumByte && !ownAddr) |=> (!txOut.valid && $stable(loadDrive)) [*2])
    else $error("foreign field caused reply or load change");

  badSum_a : assert property (
    (csumByte && ownAddr && !rxIn.csumOk) |=> ($stable(loadDrive) && !txOut.valid
      && q.csumFail))
    else $error("bad checksum not handled");

  replyAfterPush_a : assert property (
    $rose(txOut.valid) |-> $past(csumByte))
    else $error("reply started without a push field");

  rxIrq_a : assert property (
    $fell(rxLine) |=> rxIrq ##1 !rxIrq)
    else $error("start bit edge gave no interrupt pulse");

  standby_a : assert property (
    standbyOff)
    else $error("transceiver standby enabled");

  loadCov_c : cover property (
    (csumByte && ownAddr && rxIn.csumOk) ##1 txOut.valid [*3]);

  foreignCov_c : cover property (
    (csumByte && !ownAddr) ##[1:100] (q.phase == snd_pkg::PH_HDR));

  faultCov_c : cover property (
    csumByte && ownAddr && !rxIn.csumOk);

endmodule : snd_node

`default_nettype wire

// ---- bench/snd_master_model.sv ----
// bus master model: feeds push fields to the node and takes its pull bytes
`timescale 1ns/100ps
`default_nettype none

module snd_master_model (
  input  wire logic             clk_sys, // system clock
  input  wire snd_pkg::snd_tx_t txOut,   // byte offered by the node
  input  wire logic             slow,    // stall on every other cycle
  output var  snd_pkg::snd_rx_t rxIn,    // byte handed to the node
  output var  logic             txReady  // pull byte taken
);
  logic [8:0] got[$]; // appendSum and data of each pull byte

  initial
  begin
    rxIn = '0;
    txReady = 1'b0;
  end

  // a slow link accepts only every other cycle
  always @(negedge clk_sys)
    txReady <= slow ? ~txReady : 1'b1;

  // take a byte at the edge where valid and ready meet
  always @(posedge clk_sys)
    if (txOut.valid && txReady)
      got.push_back({txOut.appendSum, txOut.data});

  // push field of header, zero data, checksum
  task automatic push(input logic [7:0] hdr, input logic ok);
    @(negedge clk_sys);
    rxIn = '{valid: 1'b1, data: hdr, csumOk: 1'b0};
    @(negedge clk_sys);
    rxIn.data = 8'h00;
    @(negedge clk_sys);
    rxIn.data = 8'h5A; // stands in for the link checksum
    rxIn.csumOk = ok;
    @(negedge clk_sys);
    // released lines show a changed value, not the last byte
    rxIn = '{valid: 1'b0, data: 8'hA5, csumOk: ~ok};
  endtask : push

  // a header with nothing after it, so the field timeout is exercised
  task automatic lone(input logic [7:0] hdr);
    @(negedge clk_sys);
    rxIn = '{valid: 1'b1, data: hdr, csumOk: 1'b0};
    @(negedge clk_sys);
    rxIn = '{valid: 1'b0, data: 8'hA5, csumOk: 1'b1};
  endtask : lone
endmodule : snd_master_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking testbench of the switch node command decoder
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int GAP = 50;
  localparam int FAST = 4;
  localparam int HOLD = 40;
  logic             clk_sys, rst, rxLine, syncPulse, linkFault, slow;
  logic             txReady, loadDrive, statusLed, rxIrq, standbyOff;
  snd_pkg::snd_rx_t rxIn;
  snd_pkg::snd_tx_t txOut;
  int               err_count = 0;
  int               n_compared = 0;
  int               c;

  snd_node #(.NODE_ADDR(6), .GAP_CYC(GAP), .FAST_CYC(FAST), .HOLD_CYC(HOLD)) dut (
    .clk_sys(clk_sys), .rst(rst), .rxIn(rxIn), .txReady(txReady), .rxLine(rxLine),
    .syncPulse(syncPulse), .linkFault(linkFault), .txOut(txOut), .loadDrive(loadDrive),
    .statusLed(statusLed), .rxIrq(rxIrq), .standbyOff(standbyOff));

  snd_master_model m (.clk_sys(clk_sys), .txOut(txOut), .slow(slow), .rxIn(rxIn),
    .txReady(txReady));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // count changes of the indicator, or of the interrupt when irq is set
  task automatic edges(input int n, input logic irq, output int cnt);
    logic last;
    cnt = 0;
    last = irq ? rxIrq : statusLed;
    repeat (n)
    begin
      @(negedge clk_sys);
      if ((irq ? rxIrq : statusLed) !== last)
        cnt++;
      last = irq ? rxIrq : statusLed;
    end
  endtask : edges

  // wait for a whole pull field, or see that none comes
  task automatic pull(input logic [7:0] hdr, input int n);
    int i;
    for (i = 0; i < 20 && m.got.size() < 3; i++)
      @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pull count", 9'(m.got.size()), 9'(n));
    if (n == 3)
    begin
      chk("pull hdr", m.got[0], {1'b0, hdr});
      chk("pull data", m.got[1], 9'h000);
      chk("pull sum", m.got[2], 9'h100);
    end
    m.got.delete();
  endtask : pull

  task automatic t_load();
    m.push(8'h26, 1'b1);
    pull(8'h26, 3);
    chk("load on", loadDrive, 1'b1);
    slow = 1'b1;
    m.push(8'h46, 1'b1);
    pull(8'h46, 3);
    chk("load off", loadDrive, 1'b0);
    slow = 1'b0;
  endtask : t_load

  task automatic t_noact();
    logic [2:0] cmds[6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    m.push(8'h26, 1'b1);
    pull(8'h26, 3);
    // every inert code keeps the load
    foreach (cmds[i])
    begin
      m.push({cmds[i], 5'h06}, 1'b1);
      pull({cmds[i], 5'h06}, 3);
      chk("load kept", loadDrive, 1'b1);
    end
  endtask : t_noact

  task automatic t_other();
    m.push(8'h47, 1'b1);
    m.push(8'h47, 1'b1); // the other slave's pull
    pull(8'h00, 0);
    chk("foreign", loadDrive, 1'b1);
    m.push(8'h46, 1'b1);
    pull(8'h46, 3);
    chk("own after", loadDrive, 1'b0);
  endtask : t_other

  // a lone header must time out instead of swallowing the next field
  task automatic t_gap();
    m.lone(8'h26);
    repeat (GAP + 5) @(negedge clk_sys);
    m.push(8'h46, 1'b1);
    pull(8'h46, 3);
    chk("gap load", loadDrive, 1'b0);
  endtask : t_gap

  task automatic t_fault();
    m.push(8'h26, 1'b0);
    pull(8'h00, 0);
    chk("bad sum", loadDrive, 1'b0);
    edges(20, 1'b0, c);
    chk("fast blink", 9'(c >= 3), 9'h001);
    repeat (HOLD + 20) @(negedge clk_sys);
    linkFault = 1'b1;
    @(negedge clk_sys);
    linkFault = 1'b0;
    edges(20, 1'b0, c);
    chk("fault blink", 9'(c >= 3), 9'h001);
    repeat (HOLD + 20) @(negedge clk_sys);
    edges(20, 1'b0, c);
    chk("blink ends", 9'(c), 9'h000);
  endtask : t_fault

  task automatic t_sync();
    logic led0;
    led0 = statusLed;
    syncPulse = 1'b1;
    @(negedge clk_sys);
    syncPulse = 1'b0;
    @(negedge clk_sys);
    chk("sync toggle", statusLed ^ led0, 1'b1);
    edges(20, 1'b0, c);
    chk("led still", 9'(c), 9'h000);
  endtask : t_sync

  task automatic t_irq();
    rxLine = 1'b0;
    edges(6, 1'b1, c);
    chk("irq pulse", 9'(c), 9'h002);
    rxLine = 1'b1;
    edges(6, 1'b1, c);
    chk("irq quiet", 9'(c), 9'h000);
  endtask : t_irq

  // inputs change on the falling edge only
  initial
  begin
    rst = 1'b1;
    rxLine = 1'b1;
    syncPulse = 1'b0;
    linkFault = 1'b0;
    slow = 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset load", loadDrive, 1'b0);
    chk("reset valid", txOut.valid, 1'b0);
    chk("standby off", standbyOff, 1'b1);
    rst = 1'b0;
    t_load();
    t_noact();
    t_other();
    t_gap();
    t_fault();
    t_sync();
    t_irq();
    chk("standby end", standbyOff, 1'b1);
    stop_test();
  end

  // the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
